/* File: verilog/timer_pair_io_select.sv */
// Pin and cascade routing for base-timer channels 0 to 3.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Mode 8 takes lower cascade as startup trigger.
// - Mode 8 drives both A pins, B unused.
// - Mode 8 feeds cascade to both channels.
// - Mode 8 forwards cascade input upward.
// - Mode 2 cascade is synchronised even B pin.
// - Modes 4, 6, 7 cascade even A output.
// - Modes 3, 8 cascade pass lower trigger.
// - Software never sets modes 3, 8 on 0/1.
// - Software sets rising edge select in mode 8.
// - No rising setting with pulse width capture.
// - Falling stop trigger edge stops the timer.
// - Register holds two four-bit pair fields.
// - Bits 15:12 select channels 2/3 mode.
// - Bits 11:8 select channels 0/1 mode.
// - Rewrite only with timers in reset mode.
module timer_pair_io_select (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  pair_link_if.device     link,
  input  wire logic [1:0] even_pin_b_i,
  input  wire logic [1:0] odd_pin_b_i,
  output logic      [3:0] pin_a_o,
  output logic      [3:0] pin_a_oe_o,
  output logic            cascade_out_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic cascade_pick(
    input logic [3:0] mode,
    input logic       pin_b_even,
    input logic       wave_even,
    input logic       casc_in
  );
    logic r;
    r = 1'b0;
    unique case (mode)
      pair_io_pkg::MODE_SHARED_EXT: r = pin_b_even;
      pair_io_pkg::MODE_TIMER_SS,
      pair_io_pkg::MODE_SOFT_SS,
      pair_io_pkg::MODE_TIMER_ST:   r = wave_even;
      pair_io_pkg::MODE_SHARED_CH,
      pair_io_pkg::MODE_SHARED_SS:  r = casc_in;
      pair_io_pkg::MODE_STD16,
      pair_io_pkg::MODE_FULL,
      pair_io_pkg::MODE_SOFT_SIM:   r = 1'b0;
      // Codes above 8 are refused upstream, so the default only keeps routing quiet.
      default:                      r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic trig_pick(
    input logic [3:0] mode,
    input logic       odd,
    input logic       pin_b_own,
    input logic       pin_b_even,
    input logic       wave_even,
    input logic       casc_in
  );
    logic r;
    r = pin_b_own;
    unique case (mode)
      pair_io_pkg::MODE_SHARED_EXT: r = pin_b_even;
      pair_io_pkg::MODE_SHARED_CH,
      pair_io_pkg::MODE_SHARED_SS:  r = casc_in;
      pair_io_pkg::MODE_TIMER_SS,
      pair_io_pkg::MODE_TIMER_ST:   r = odd ? wave_even : pin_b_own;
      pair_io_pkg::MODE_SOFT_SIM,
      pair_io_pkg::MODE_SOFT_SS:    r = odd ? wave_even : 1'b0;
      pair_io_pkg::MODE_STD16,
      pair_io_pkg::MODE_FULL:       r = pin_b_own;
      default:                      r = pin_b_own;
    endcase
    return r;
  endfunction

  function automatic logic uses_stop(
    input logic [3:0] mode,
    input logic       odd
  );
    logic r;
    r = (mode == pair_io_pkg::MODE_SHARED_SS);
    if (odd && (mode == pair_io_pkg::MODE_TIMER_SS
             || mode == pair_io_pkg::MODE_SOFT_SS)) begin
      r = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [3:0] pair_field(
    input logic [15:0] sel,
    input int unsigned lsb
  );
    return sel[lsb +: pair_io_pkg::FIELD_W];
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] sel_q, sel_d;
  logic [3:0]  trig_q, trig_d;
  logic [3:0]  start_q, start_d;
  logic [3:0]  stop_q, stop_d;
  logic [3:0]  pin_a_q, pin_a_d;
  logic [3:0]  oe_q, oe_d;
  logic        casc_q, casc_d;
  logic [3:0]  pin_b_s;
  logic [3:0]  mode01, mode23, mode_c;
  logic        casc01;

  // Pins arrive from outside the clock domain, so they pass the filter first.
  pin_sync3 u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     ({odd_pin_b_i[1], even_pin_b_i[1], odd_pin_b_i[0], even_pin_b_i[0]}),
    .pin_o     (pin_b_s)
  );

  // ----------------------------------------
  // Select register
  // ----------------------------------------
  always_comb begin
    sel_d = sel_q;
    if (link.sel_wr) begin
      // Only the two pair fields exist; the low byte reads as zero.
      sel_d = link.sel_wdata & pair_io_pkg::SEL_MASK;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sel_q <= pair_io_pkg::SEL_RESET;
    end else begin
      sel_q <= sel_d;
    end
  end

  // ----------------------------------------
  // Routing and edge detection
  // ----------------------------------------
  always_comb begin
    mode23 = pair_field(sel_q, pair_io_pkg::PAIR23_LSB);
    mode01 = pair_field(sel_q, pair_io_pkg::PAIR01_LSB);
    for (int c = 0; c < 4; c++) begin
      mode_c = (c < 2) ? mode01 : mode23;
      trig_d[c] = trig_pick(mode_c, c[0], pin_b_s[c], pin_b_s[c & 2],
                            link.channel_waveform_out[c & 2], (c < 2) ? 1'b0 : casc01);
      // The registered level gives a clean edge in the peripheral clock.
      start_d[c] = trig_d[c] && !trig_q[c];
      stop_d[c]  = !trig_d[c] && trig_q[c]
                   && uses_stop(mode_c, c[0]);
      pin_a_d[c] = link.channel_waveform_out[c];
      oe_d[c]    = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      trig_q  <= 4'h0;
      start_q <= 4'h0;
      stop_q  <= 4'h0;
      pin_a_q <= 4'h0;
      oe_q    <= 4'h0;
    end else begin
      trig_q  <= trig_d;
      start_q <= start_d;
      stop_q  <= stop_d;
      pin_a_q <= pin_a_d;
      oe_q    <= oe_d;
    end
  end

  // ----------------------------------------
  // Cascade toward higher channels
  // ----------------------------------------
  always_comb begin
    // Nothing sits below channels 0 and 1, so their cascade input is tied low.
    casc01 = cascade_pick(mode01, pin_b_s[0], link.channel_waveform_out[0], 1'b0);
    casc_d = cascade_pick(mode23, pin_b_s[2], link.channel_waveform_out[2], casc01);
  end

  // One flop here keeps the path into the next pair short at the cost of a cycle.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      casc_q <= 1'b0;
    end else begin
      casc_q <= casc_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.sel_rdata   = sel_q;
  assign link.trig_level  = trig_q;
  assign link.start_pulse = start_q;
  assign link.stop_pulse  = stop_q;
  assign pin_a_o          = pin_a_q;
  assign pin_a_oe_o       = oe_q;
  assign cascade_out_o    = casc_q;

endmodule
`default_nettype wire

/* File: inc/pair_io_pkg.sv */
// Shared constants and types for the timer pair I/O select block.
package pair_io_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int unsigned NCH     = 4;
  localparam int unsigned REG_W   = 16;
  localparam int unsigned FIELD_W = 4;

  // ----------------------------------------
  // Select register layout and reset value
  // ----------------------------------------
  localparam int unsigned        PAIR23_LSB = 12;
  localparam int unsigned        PAIR01_LSB = 8;
  localparam logic [REG_W-1:0]   SEL_RESET  = 16'h0000;
  localparam logic [REG_W-1:0]   SEL_MASK   = 16'hFF00;

  // ----------------------------------------
  // Pair modes
  // ----------------------------------------
  typedef enum logic [FIELD_W-1:0] {
    MODE_STD16      = 4'h0,
    MODE_FULL       = 4'h1,
    MODE_SHARED_EXT = 4'h2,
    MODE_SHARED_CH  = 4'h3,
    MODE_TIMER_SS   = 4'h4,
    MODE_SOFT_SIM   = 4'h5,
    MODE_SOFT_SS    = 4'h6,
    MODE_TIMER_ST   = 4'h7,
    MODE_SHARED_SS  = 4'h8
  } mode_t;

  // ----------------------------------------
  // Timer control field values
  // ----------------------------------------
  localparam logic [2:0] FUNC_RESET   = 3'h0;
  localparam logic [2:0] FUNC_CAPTURE = 3'h4;
  localparam logic [1:0] EGS_RISING   = 2'h1;
  localparam logic [1:0] EGS_RESET    = 2'h0;

  // ----------------------------------------
  // Channel waveform model timing
  // ----------------------------------------
  localparam logic [3:0] WAVE_HALF_CYC = 4'h7;
  localparam logic [3:0] CNT_RESET     = 4'h0;

endpackage

/* File: inc/pair_link_if.sv */
// Link between the pair I/O select and the timer channels around it.
`timescale 1ns/10ps
`default_nettype none
interface pair_link_if;
  logic [3:0]  channel_waveform_out;
  logic [3:0]  trig_level;
  logic [3:0]  start_pulse;
  logic [3:0]  stop_pulse;
  logic        sel_wr;
  logic [15:0] sel_wdata;
  logic [15:0] sel_rdata;

  modport device (
    input  channel_waveform_out,
    input  sel_wr,
    input  sel_wdata,
    output trig_level,
    output start_pulse,
    output stop_pulse,
    output sel_rdata
  );

  modport partner (
    output channel_waveform_out,
    output sel_wr,
    output sel_wdata,
    input  trig_level,
    input  start_pulse,
    input  stop_pulse,
    input  sel_rdata
  );
endinterface
`default_nettype wire

/* File: verilog/pin_sync3.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] pin_i,
  output logic      [3:0] pin_o
);

  logic [3:0] s1_q, s2_q, s3_q, out_q;
  logic [3:0] out_d;

  // ----------------------------------------
  // Filter
  // ----------------------------------------
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < 4; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_q  <= 4'h0;
      s2_q  <= 4'h0;
      s3_q  <= 4'h0;
      out_q <= 4'h0;
    end else begin
      s1_q  <= pin_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign pin_o = out_q;

endmodule
`default_nettype wire

/* File: verilog/timer_pair_partner.sv */
// Timer channels and software writer facing the pair I/O select.
`timescale 1ns/10ps
`default_nettype none
module timer_pair_partner (
  input  wire logic            ref_clk_i,
  input  wire logic            rst_i,
  pair_link_if.partner         link,
  input  wire logic [3:0][2:0] function_select_i,
  input  wire logic [3:0][1:0] edge_select_i,
  input  wire logic            sel_req_i,
  input  wire logic [15:0]     sel_data_i,
  output logic                 refused_o,
  output logic      [3:0]      running_o,
  output logic      [3:0][1:0] edge_select_o
);

  logic            wr_q, wr_d, ref_q, ref_d;
  logic [15:0]     wdata_q, wdata_d;
  logic [3:0]      run_q, run_d, wave_q, wave_d;
  logic [3:0][3:0] cnt_q, cnt_d;
  logic [3:0][1:0] egs_q, egs_d;
  logic            all_reset, code_ok;
  logic [3:0]      m01, m23, m;

  // ----------------------------------------
  // Software side of the select register
  // ----------------------------------------
  always_comb begin
    all_reset = 1'b1;
    for (int c = 0; c < 4; c++) begin
      if (function_select_i[c] != pair_io_pkg::FUNC_RESET) begin
        all_reset = 1'b0;
      end
    end
    m01 = sel_data_i[pair_io_pkg::PAIR01_LSB +: 4];
    m23 = sel_data_i[pair_io_pkg::PAIR23_LSB +: 4];
    code_ok = (m01 <= 4'h8) && (m23 <= 4'h8);
    if (m01 == 4'h3 || m01 == 4'h8) begin
      code_ok = 1'b0;
    end
    wr_d    = sel_req_i && all_reset && code_ok;
    ref_d   = sel_req_i && !(all_reset && code_ok);
    wdata_d = sel_data_i;
  end

  // ----------------------------------------
  // Channel models
  // ----------------------------------------
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      m = (c < 2) ? link.sel_rdata[pair_io_pkg::PAIR01_LSB +: 4]
                  : link.sel_rdata[pair_io_pkg::PAIR23_LSB +: 4];
      egs_d[c] = edge_select_i[c];
      if (m == 4'h8 && function_select_i[c] != pair_io_pkg::FUNC_CAPTURE) begin
        egs_d[c] = pair_io_pkg::EGS_RISING;
      end
      run_d[c]  = run_q[c];
      if (function_select_i[c] == pair_io_pkg::FUNC_RESET) begin
        run_d[c] = 1'b0;
      end else if (link.stop_pulse[c]) begin
        run_d[c] = 1'b0;
      end else if (link.start_pulse[c] && egs_q[c] == pair_io_pkg::EGS_RISING) begin
        run_d[c] = 1'b1;
      end
      cnt_d[c]  = cnt_q[c];
      wave_d[c] = wave_q[c];
      if (!run_q[c]) begin
        cnt_d[c]  = pair_io_pkg::CNT_RESET;
        wave_d[c] = 1'b0;
      end else if (cnt_q[c] == pair_io_pkg::WAVE_HALF_CYC) begin
        cnt_d[c]  = pair_io_pkg::CNT_RESET;
        wave_d[c] = !wave_q[c];
      end else begin
        cnt_d[c] = cnt_q[c] + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_q    <= 1'b0;
      ref_q   <= 1'b0;
      wdata_q <= 16'h0000;
      run_q   <= 4'h0;
      wave_q  <= 4'h0;
      cnt_q   <= '0;
      egs_q   <= '0;
    end else begin
      wr_q    <= wr_d;
      ref_q   <= ref_d;
      wdata_q <= wdata_d;
      run_q   <= run_d;
      wave_q  <= wave_d;
      cnt_q   <= cnt_d;
      egs_q   <= egs_d;
    end
  end

  assign link.sel_wr               = wr_q;
  assign link.sel_wdata            = wdata_q;
  assign link.channel_waveform_out = wave_q;
  assign refused_o                 = ref_q;
  assign running_o                 = run_q;
  assign edge_select_o             = egs_q;

endmodule
`default_nettype wire

/* File: bench/timer_pair_io_select_sva.sv */
// Assertions on the link between the pair I/O select and its timer channels.
`timescale 1ns/10ps
`default_nettype none
module timer_pair_io_select_sva (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  channel_waveform_out,
  input  wire logic [3:0]  trig_level,
  input  wire logic [3:0]  start_pulse,
  input  wire logic [3:0]  stop_pulse,
  input  wire logic        sel_wr,
  input  wire logic [15:0] sel_wdata,
  input  wire logic [15:0] sel_rdata,
  input  wire logic [3:0]  pin_a_o,
  input  wire logic [3:0]  pin_a_oe_o,
  input  wire logic        cascade_out_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic m8;
  // Routing follows the stored mode one edge late, so mode 8 must have held a cycle.
  assign m8 = (sel_rdata[15:12] == 4'h8);
  property p_sel_update;
    sel_wr |=> sel_rdata == ($past(sel_wdata) & 16'hFF00);
  endproperty
  a_sel_update: assert property (p_sel_update) else $error("select write not stored");
  property p_sel_hold;
    !sel_wr |=> $stable(sel_rdata);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed without write");
  property p_low_byte;
    sel_rdata[7:0] == 8'h00;
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("select low byte not zero");
  property p_pair01_legal;
    sel_rdata[11:8] != 4'h3 && sel_rdata[11:8] != 4'h8;
  endproperty
  a_pair01_legal: assert property (p_pair01_legal) else $error("lowest pair mode illegal");
  property p_pin_a;
    pin_a_o == $past(channel_waveform_out);
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("A pins do not follow waveforms");
  property p_oe;
    !$past(rst_i) |-> pin_a_oe_o == 4'hF;
  endproperty
  a_oe: assert property (p_oe) else $error("A pins not driven");
  property p_trig_pair;
    m8 && $past(m8) |-> trig_level[3] == trig_level[2];
  endproperty
  a_trig_pair: assert property (p_trig_pair) else $error("pair triggers differ");
  property p_cascade_fwd;
    m8 && $past(m8) |-> cascade_out_o == trig_level[2];
  endproperty
  a_cascade_fwd: assert property (p_cascade_fwd) else $error("cascade not forwarded");
  property p_stop;
    m8 && $past(m8) && $fell(trig_level[2]) |-> stop_pulse[3:2] == 2'b11;
  endproperty
  a_stop: assert property (p_stop) else $error("falling trigger gave no stop");
  property p_start;
    start_pulse[2] == $rose(trig_level[2]);
  endproperty
  a_start: assert property (p_start) else $error("start pulse not on rising trigger");
endmodule
`default_nettype wire

/* File: bench/test_timer_pair_io_select.sv */
// Self-checking bench for the pair I/O select facing its timer channels.
`timescale 1ns/10ps
`default_nettype none
module test_timer_pair_io_select;
  logic            ref_clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic [1:0]      even_pin_b_i = 2'h0;
  logic [1:0]      odd_pin_b_i = 2'h0;
  logic [3:0][2:0] function_select_i = 12'h000;
  logic [3:0][1:0] edge_select_i = 8'h00;
  logic            sel_req_i = 1'b0;
  logic [15:0]     sel_data_i = 16'h0000;
  logic            refused_o;
  logic            cascade_out_o;
  logic            rf;
  logic [3:0]      running_o;
  logic [3:0]      pin_a_o;
  logic [3:0]      pin_a_oe_o;
  logic [3:0][1:0] edge_select_o;
  logic [15:0]     e;
  int              fails = 0;
  int              n_tests = 0;
  int              i;
  pair_link_if link ();
  timer_pair_partner u_timer_pair_partner (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link),
    .function_select_i(function_select_i), .edge_select_i(edge_select_i),
    .sel_req_i(sel_req_i), .sel_data_i(sel_data_i), .refused_o(refused_o),
    .running_o(running_o), .edge_select_o(edge_select_o));
  timer_pair_io_select u_timer_pair_io_select (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .link(link), .even_pin_b_i(even_pin_b_i), .odd_pin_b_i(odd_pin_b_i),
    .pin_a_o(pin_a_o), .pin_a_oe_o(pin_a_oe_o), .cascade_out_o(cascade_out_o));
  timer_pair_io_select_sva u_timer_pair_io_select_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .channel_waveform_out(link.channel_waveform_out), .trig_level(link.trig_level),
    .start_pulse(link.start_pulse),
    .stop_pulse(link.stop_pulse), .sel_wr(link.sel_wr), .sel_wdata(link.sel_wdata),
    .sel_rdata(link.sel_rdata), .pin_a_o(pin_a_o), .pin_a_oe_o(pin_a_oe_o),
    .cascade_out_o(cascade_out_o));
  always #10 ref_clk_i = ~ref_clk_i;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Refusal is sampled on two edges so either reading of the answer cycle is caught.
  task wr(input logic [15:0] d);
    @(negedge ref_clk_i);
    sel_req_i = 1'b1;
    sel_data_i = d;
    @(negedge ref_clk_i);
    sel_req_i = 1'b0;
    rf = refused_o;
    @(negedge ref_clk_i);
    rf = rf | refused_o;
    @(negedge ref_clk_i);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reg;
    for (int m = 0; m < 9; m++) begin
      wr({m[3:0], 4'h2, 8'hFF});
      check("upper field", {m[3:0], 12'h200}, link.sel_rdata);
    end
    e = 16'h8200;
    for (int m = 0; m < 9; m++) begin
      wr({4'h0, m[3:0], 8'h00});
      if (m != 3 && m != 8) e = {4'h0, m[3:0], 8'h00};
      check("lower refused", {15'h0000, m == 3 || m == 8}, {15'h0000, rf});
      check("lower field", e, link.sel_rdata);
    end
    wr(16'h9000);
    check("code nine refused", 16'h0001, {15'h0000, rf});
    function_select_i[1] = 3'h1;
    wr(16'h0100);
    check("busy refused", 16'h0001, {15'h0000, rf});
    function_select_i = 12'h000;
    $display("t_reg done");
  endtask
  task t_chain(input logic [3:0] up);
    wr({up, 4'h2, 8'h00});
    function_select_i = 12'h249;
    @(negedge ref_clk_i);
    even_pin_b_i[0] = 1'b1;
    for (i = 0; i < 12 && cascade_out_o !== 1'b1; i++) @(negedge ref_clk_i);
    check("cascade rise", 16'h0001, {15'h0000, cascade_out_o});
    if (up == 4'h8) begin
      check("pair trigger", 16'h0003, {14'h0000, link.trig_level[3:2]});
      check("edge forced", 16'h0005, {12'h000, edge_select_o[3], edge_select_o[2]});
      repeat (3) @(negedge ref_clk_i);
      check("pair started", 16'h0003, {14'h0000, running_o[3:2]});
    end
    even_pin_b_i[0] = 1'b0;
    for (i = 0; i < 12 && cascade_out_o !== 1'b0; i++) @(negedge ref_clk_i);
    check("cascade fall", 16'h0000, {15'h0000, cascade_out_o});
    repeat (3) @(negedge ref_clk_i);
    if (up == 4'h8) check("pair stopped", 16'h0000, {14'h0000, running_o[3:2]});
    function_select_i = 12'h000;
    repeat (4) @(negedge ref_clk_i);
    $display("t_chain done");
  endtask
  task t_cascade_a(input logic [3:0] lo);
    wr({4'h8, lo, 8'h00});
    function_select_i = 12'h249;
    edge_select_i = 8'h55;
    @(negedge ref_clk_i);
    even_pin_b_i[0] = 1'b1;
    for (i = 0; i < 40 && link.channel_waveform_out[0] !== 1'b1; i++) @(negedge ref_clk_i);
    repeat (3) @(negedge ref_clk_i);
    check("cascade from even A", 16'h0001, {15'h0000, cascade_out_o});
    check("even pin A level", 16'h0001, {15'h0000, pin_a_o[0]});
    even_pin_b_i[0] = 1'b0;
    function_select_i = 12'h000;
    edge_select_i = 8'h00;
    repeat (20) @(negedge ref_clk_i);
    $display("t_cascade_a done");
  endtask
  task t_capture;
    wr(16'h8200);
    function_select_i[2] = 3'h4;
    repeat (3) @(negedge ref_clk_i);
    check("edge kept for capture", 16'h0000, {14'h0000, edge_select_o[2]});
    function_select_i = 12'h000;
    repeat (2) @(negedge ref_clk_i);
    $display("t_capture done");
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    fails++;
    print_verdict;
  end
  initial begin
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    check("select reset", 16'h0000, link.sel_rdata);
    check("pin enables", 16'h000F, {12'h000, pin_a_oe_o});
    t_reg;
    t_chain(4'h8);
    t_chain(4'h3);
    t_cascade_a(4'h4);
    t_cascade_a(4'h7);
    t_capture;
    print_verdict;
  end
endmodule
`default_nettype wire
